/* hw/cic_pkg.sv */
// Constants, register map and field layout of the core interrupt control.
package cic_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int PERIPH_W = 7;
  localparam int EVT_W = 4;

  // Control register and its three mirrors.
  localparam logic [8:0] INTERRUPT_CONTROL_OFS0 = 9'h00b;
  localparam logic [8:0] INTERRUPT_CONTROL_OFS1 = 9'h08b;
  localparam logic [8:0] INTERRUPT_CONTROL_OFS2 = 9'h10b;
  localparam logic [8:0] INTERRUPT_CONTROL_OFS3 = 9'h18b;
  // Peripheral enable register.
  localparam logic [8:0] PERIPHERAL_IRQ_ENABLE_ONE_OFS = 9'h08c;
  // Sticky event status and its mask.
  localparam logic [8:0] EVENT_STATUS_OFS = 9'h190;
  localparam logic [8:0] EVENT_MASK_OFS = 9'h191;

  // Control register fields.
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int TIMER_OVERFLOW_ENABLE_BIT = 5;
  localparam int EXTERNAL_PIN_IRQ_ENABLE_BIT = 4;
  localparam int PORT_CHANGE_ENABLE_BIT = 3;
  localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
  localparam int EXTERNAL_PIN_IRQ_FLAG_BIT = 1;
  localparam int PORT_CHANGE_FLAG_BIT = 0;

  // Peripheral enable fields.
  localparam int CONVERSION_DONE_ENABLE_BIT = 6;
  localparam int SERIAL_RECEIVE_ENABLE_BIT = 5;
  localparam int SERIAL_TRANSMIT_ENABLE_BIT = 4;
  localparam int SYNC_SERIAL_ENABLE_BIT = 3;
  localparam int CAPTURE_COMPARE_ENABLE_BIT = 2;
  localparam int TIMER_TWO_MATCH_ENABLE_BIT = 1;
  localparam int TIMER_ONE_OVERFLOW_ENABLE_BIT = 0;

  // Event status fields.
  localparam int EVT_TIMER_BIT = 0;
  localparam int EVT_EXT_PIN_BIT = 1;
  localparam int EVT_PORT_CHANGE_BIT = 2;
  localparam int EVT_PERIPH_BIT = 3;

  // Reset values.
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [6:0] PERIPHERAL_IRQ_ENABLE_ONE_RST = 7'h00;
  localparam logic [3:0] EVENT_RST = 4'h0;

  // Cycles after reset release before pin edges are trusted.
  localparam logic [1:0] SYNC_ARM_CYCLES = 2'h2;

endpackage : cic_pkg

/* hw/cic_evt_if.sv */
// Synchronised pin events passed from the pin front end to the controller.
`timescale 1ns/1ps
interface cic_evt_if;
  logic ext_edge;
  logic [7:0] pin_change_a;
  logic [7:0] pin_change_b;

  modport src (output ext_edge, output pin_change_a, output pin_change_b);
  modport snk (input ext_edge, input pin_change_a, input pin_change_b);
endinterface : cic_evt_if

/* hw/cic_pin_sync.sv */
// Pin synchronisers with edge and change detection.
`timescale 1ns/1ps
module cic_pin_sync
  import cic_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins and edge select.
  input wire logic external_irq_pin,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic ext_edge_rising,
  // Events out.
  cic_evt_if.src evt
);

  typedef struct packed {
    logic [1:0] arm;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [7:0] a_s1;
    logic [7:0] a_s2;
    logic [7:0] a_prev;
    logic [7:0] b_s1;
    logic [7:0] b_s2;
    logic [7:0] b_prev;
  } cic_sync_t;

  cic_sync_t sync_reg;
  cic_sync_t sync_next;
  logic armed;

  assign armed = (sync_reg.arm == SYNC_ARM_CYCLES);

  always_comb
  begin
    sync_next = sync_reg;
    sync_next.ext_s1 = external_irq_pin;
    sync_next.ext_s2 = sync_reg.ext_s1;
    sync_next.ext_prev = sync_reg.ext_s2;
    sync_next.a_s1 = port_a_pins;
    sync_next.a_s2 = sync_reg.a_s1;
    sync_next.a_prev = sync_reg.a_s2;
    sync_next.b_s1 = port_b_pins;
    sync_next.b_s2 = sync_reg.b_s1;
    sync_next.b_prev = sync_reg.b_s2;
    if (!armed)
    begin
      sync_next.arm = sync_reg.arm + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  // Edges are suppressed until the arm count reaches SYNC_ARM_CYCLES, one cycle before the history flops hold real pin levels.
  assign evt.ext_edge = armed && (ext_edge_rising ?
    (sync_reg.ext_s2 && !sync_reg.ext_prev) :
    (!sync_reg.ext_s2 && sync_reg.ext_prev));
  assign evt.pin_change_a = armed ? (sync_reg.a_s2 ^ sync_reg.a_prev) : '0;
  assign evt.pin_change_b = armed ? (sync_reg.b_s2 ^ sync_reg.b_prev) : '0;

endmodule : cic_pin_sync

/* hw/cic_sticky.sv */
// Sticky event status with write-one-to-clear, mask and level interrupt.
`timescale 1ns/1ps
module cic_sticky
  import cic_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Event pulses.
  input wire logic [3:0] evt_set,
  // Software access.
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [3:0] wr_data,
  // State and interrupt.
  output logic [3:0] status,
  output logic [3:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] mask;
    logic irq;
  } cic_stk_t;

  cic_stk_t stk_reg;
  cic_stk_t stk_next;

  always_comb
  begin
    stk_next = stk_reg;
    if (status_wr)
    begin
      stk_next.status = stk_reg.status & ~wr_data;
    end
    // A new event outranks a clear in the same cycle.
    stk_next.status = stk_next.status | evt_set;
    if (mask_wr)
    begin
      stk_next.mask = wr_data;
    end
    stk_next.irq = |(stk_next.status & stk_next.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stk_reg <= '{status: EVENT_RST, mask: EVENT_RST, irq: 1'b0};
    end
    else
    begin
      stk_reg <= stk_next;
    end
  end

  assign status = stk_reg.status;
  assign mask = stk_reg.mask;
  assign irq = stk_reg.irq;

endmodule : cic_sticky

/* hw/cic_top.sv */
// Interrupt control and enable registers of the core, with request logic.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module cic_top
  import cic_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core side event sources.
  input wire logic timer_rollover,
  input wire logic low_power_wakeup,
  input wire logic ext_edge_rising,
  input wire logic [6:0] periph_flags,
  // Per-pin change masks from the port block.
  input wire logic [7:0] port_a_pin_change_mask,
  input wire logic [7:0] port_b_pin_change_mask,
  // Pins.
  input wire logic external_irq_pin,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  // Interrupt outputs.
  output logic irq_to_core,
  output logic irq_event
);

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
    logic timer_overflow_enable;
    logic external_pin_irq_enable;
    logic port_change_enable;
    logic timer_overflow_flag;
    logic external_pin_irq_flag;
    logic port_change_flag;
  } cic_ctl_t;

  typedef struct packed {
    cic_ctl_t ctl;
    logic [6:0] peripheral_irq_enable_one;
    logic [7:0] rdata;
    logic irq;
  } cic_state_t;

  cic_state_t st_reg;
  cic_state_t st_next;

  cic_evt_if evt_bus ();

  logic port_change_evt;
  logic periph_req;
  logic core_req;
  logic [3:0] evt_set;
  logic [3:0] evt_status;
  logic [3:0] evt_mask;
  logic evt_irq;
  logic wr_ctl;
  logic wr_peripheral_irq_enable_one;
  logic wr_evt_status;
  logic wr_evt_mask;

  // Decode of the control register and its mirrors.
  function automatic logic is_ctl(input logic [8:0] a);
    is_ctl = (a == INTERRUPT_CONTROL_OFS0) ||
             (a == INTERRUPT_CONTROL_OFS1) ||
             (a == INTERRUPT_CONTROL_OFS2) ||
             (a == INTERRUPT_CONTROL_OFS3);
  endfunction : is_ctl

  // Control register image.
  function automatic logic [7:0] ctl_image(input cic_ctl_t c);
    ctl_image = 8'h00;
    ctl_image[GLOBAL_IRQ_ENABLE_BIT] = c.global_irq_enable;
    ctl_image[PERIPHERAL_GROUP_ENABLE_BIT] = c.peripheral_group_enable;
    ctl_image[TIMER_OVERFLOW_ENABLE_BIT] = c.timer_overflow_enable;
    ctl_image[EXTERNAL_PIN_IRQ_ENABLE_BIT] = c.external_pin_irq_enable;
    ctl_image[PORT_CHANGE_ENABLE_BIT] = c.port_change_enable;
    ctl_image[TIMER_OVERFLOW_FLAG_BIT] = c.timer_overflow_flag;
    ctl_image[EXTERNAL_PIN_IRQ_FLAG_BIT] = c.external_pin_irq_flag;
    ctl_image[PORT_CHANGE_FLAG_BIT] = c.port_change_flag;
  endfunction : ctl_image

  cic_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .external_irq_pin(external_irq_pin),
    .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins),
    .ext_edge_rising(ext_edge_rising),
    .evt(evt_bus.src)
  );

  assign port_change_evt =
    (|(evt_bus.pin_change_a & port_a_pin_change_mask)) ||
    (|(evt_bus.pin_change_b & port_b_pin_change_mask)) ||
    low_power_wakeup;

  assign periph_req = |(periph_flags & st_reg.peripheral_irq_enable_one);

  assign core_req =
    (st_reg.ctl.timer_overflow_enable && st_reg.ctl.timer_overflow_flag) ||
    (st_reg.ctl.external_pin_irq_enable &&
     st_reg.ctl.external_pin_irq_flag) ||
    (st_reg.ctl.port_change_enable && st_reg.ctl.port_change_flag);

  assign wr_ctl = reg_wr && is_ctl(reg_addr);
  assign wr_peripheral_irq_enable_one = reg_wr && (reg_addr == PERIPHERAL_IRQ_ENABLE_ONE_OFS);
  assign wr_evt_status = reg_wr && (reg_addr == EVENT_STATUS_OFS);
  assign wr_evt_mask = reg_wr && (reg_addr == EVENT_MASK_OFS);

  always_comb
  begin
    evt_set = EVENT_RST;
    evt_set[EVT_TIMER_BIT] = timer_rollover;
    evt_set[EVT_EXT_PIN_BIT] = evt_bus.ext_edge;
    evt_set[EVT_PORT_CHANGE_BIT] = port_change_evt;
    evt_set[EVT_PERIPH_BIT] = periph_req && !st_reg.irq;
  end

  cic_sticky u_sticky (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .evt_set(evt_set),
    .status_wr(wr_evt_status),
    .mask_wr(wr_evt_mask),
    .wr_data(reg_wdata[3:0]),
    .status(evt_status),
    .mask(evt_mask),
    .irq(evt_irq)
  );

  always_comb
  begin
    st_next = st_reg;

    if (wr_ctl)
    begin
      st_next.ctl = cic_ctl_t'(reg_wdata);
    end

    if (wr_peripheral_irq_enable_one)
    begin
      st_next.peripheral_irq_enable_one = reg_wdata[6:0];
    end

    if (timer_rollover)
    begin
      st_next.ctl.timer_overflow_flag = 1'b1;
    end
    if (evt_bus.ext_edge)
    begin
      st_next.ctl.external_pin_irq_flag = 1'b1;
    end
    if (port_change_evt)
    begin
      st_next.ctl.port_change_flag = 1'b1;
    end

    // Read data stand for one cycle after the strobe.
    st_next.rdata = 8'h00;
    if (reg_rd)
    begin
      if (is_ctl(reg_addr))
      begin
        st_next.rdata = ctl_image(st_reg.ctl);
      end
      else if (reg_addr == PERIPHERAL_IRQ_ENABLE_ONE_OFS)
      begin
        st_next.rdata = {1'b0, st_reg.peripheral_irq_enable_one};
      end
      else if (reg_addr == EVENT_STATUS_OFS)
      begin
        st_next.rdata = {4'h0, evt_status};
      end
      else if (reg_addr == EVENT_MASK_OFS)
      begin
        st_next.rdata = {4'h0, evt_mask};
      end
    end

    st_next.irq = st_reg.ctl.global_irq_enable &&
      (core_req || (st_reg.ctl.peripheral_group_enable && periph_req));
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '{ctl: cic_ctl_t'(INTERRUPT_CONTROL_RST),
                  peripheral_irq_enable_one: PERIPHERAL_IRQ_ENABLE_ONE_RST,
                  rdata: 8'h00,
                  irq: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign irq_to_core = st_reg.irq;
  assign irq_event = evt_irq;

endmodule : cic_top

/* test/cic_src_model.sv */
// Model of the core-side sources: timer, wake-up, pins, peripherals.
`timescale 1ns/1ps
module cic_src_model (
  // Clock and commands.
  input wire logic clk_sys,
  input wire logic [2:0] op,
  input wire logic [7:0] arg,
  // Sources.
  output logic timer_rollover,
  output logic low_power_wakeup,
  output logic external_irq_pin,
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [6:0] periph_flags
);
  initial
  begin
    external_irq_pin = 1'b0;
    port_a_pins = 8'h00;
    port_b_pins = 8'h00;
    periph_flags = 7'h00;
  end
  always @(posedge clk_sys)
  begin
    timer_rollover <= op == 3'h1;
    low_power_wakeup <= op == 3'h3;
    if (op == 3'h2)
      external_irq_pin <= ~external_irq_pin;
    if (op == 3'h4)
      port_a_pins <= port_a_pins ^ arg;
    if (op == 3'h5)
      port_b_pins <= port_b_pins ^ arg;
    if (op == 3'h6)
      periph_flags <= arg[6:0];
  end
endmodule : cic_src_model

/* test/cic_top_assertions.sv */
// Concurrent checks on the ports of the interrupt control top.
`timescale 1ns/1ps
module cic_top_assertions
  import cic_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sources and outputs.
  input wire logic timer_rollover,
  input wire logic low_power_wakeup,
  input wire logic [6:0] periph_flags,
  input wire logic irq_to_core,
  input wire logic irq_event
);
  logic [7:3] en_reg;
  logic [6:0] pie_reg;
  logic gp_on, per_hit, core_off;
  assign gp_on = en_reg[7] & en_reg[6];
  assign per_hit = |(periph_flags & pie_reg);
  assign core_off = en_reg[5:3] == 3'h0;
  // Shadow of the enables; flags are not tracked here.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_reg <= 5'h00;
      pie_reg <= 7'h00;
    end
    else
    begin
      if (reg_wr && reg_addr[6:0] == 7'h0b)
        en_reg <= reg_wdata[7:3];
      if (reg_wr && reg_addr == PERIPHERAL_IRQ_ENABLE_ONE_OFS)
        pie_reg <= reg_wdata[6:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle:
  assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  chk_pie_top_zero:
  assert property ($past(reg_rd) && $past(reg_addr) ==
    PERIPHERAL_IRQ_ENABLE_ONE_OFS |-> !reg_rdata[7])
    else $error("peripheral enable bit 7 not zero");
  chk_global_block:
  assert property (!en_reg[7] && !$past(en_reg[7]) |-> !irq_to_core)
    else $error("request with global enable clear");
  chk_group_block:
  assert property (en_reg[6:3] == 4'h0 && $past(core_off)
    && !$past(en_reg[6]) |-> !irq_to_core)
    else $error("peripheral request without group enable");
  chk_periph_pass:
  assert property ($past(gp_on) && $past(per_hit) |-> irq_to_core)
    else $error("enabled peripheral request not passed");
  chk_periph_mask:
  assert property ($past(core_off) && !$past(per_hit) |-> !irq_to_core)
    else $error("masked peripheral request passed");
  chk_timer_path:
  assert property (timer_rollover && !reg_wr && en_reg[7] && en_reg[5]
    ##1 !reg_wr |-> ##1 irq_to_core)
    else $error("timer rollover request late or missing");
  chk_wake_path:
  assert property (low_power_wakeup && !reg_wr && en_reg[7] && en_reg[3]
    ##1 !reg_wr |-> ##1 irq_to_core)
    else $error("wake-up request late or missing");
  chk_event_drop:
  assert property ($fell(irq_event) |-> $past(reg_wr) && ($past(reg_addr)
    == EVENT_STATUS_OFS || $past(reg_addr) == EVENT_MASK_OFS))
    else $error("event line dropped without a write");
endmodule : cic_top_assertions
bind cic_top cic_top_assertions cic_top_assertions_i (.clk_sys, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_rollover,
  .low_power_wakeup, .periph_flags, .irq_to_core, .irq_event);

/* test/testbench.sv */
// Self-checking bench for the core interrupt control.
`timescale 1ns/1ps
module testbench;
  import cic_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, ext_edge_rising, rd_seen;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, arg, v;
  logic [7:0] port_a_pin_change_mask, port_b_pin_change_mask;
  logic [2:0] op;
  logic timer_rollover, low_power_wakeup, external_irq_pin;
  logic irq_to_core, irq_event;
  logic [7:0] port_a_pins, port_b_pins;
  logic [6:0] periph_flags;
  logic [7:0] expq[$];
  int fails = 0;
  int tests_run = 0;
  cic_top cic_top_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .timer_rollover, .low_power_wakeup,
    .ext_edge_rising, .periph_flags, .port_a_pin_change_mask,
    .port_b_pin_change_mask, .external_irq_pin, .port_a_pins,
    .port_b_pins, .irq_to_core, .irq_event);
  cic_src_model cic_src_model_i (.clk_sys, .op, .arg, .timer_rollover,
    .low_power_wakeup, .external_irq_pin, .port_a_pins, .port_b_pins,
    .periph_flags);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [8:0] a, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic src(logic [2:0] o, logic [7:0] a);
    @(posedge clk_sys);
    op <= o;
    arg <= a;
    @(posedge clk_sys);
    op <= 3'h0;
  endtask : src
  task automatic irq_is(logic e);
    repeat (3) @(posedge clk_sys);
    check("irq_to_core", {7'h00, irq_to_core}, {7'h00, e});
  endtask : irq_is
  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk_sys)
  begin
    if (rd_seen)
      check("reg_rdata", reg_rdata, expq.pop_front());
    rd_seen <= reg_rd;
  end
  initial
  begin
    #2000000;
    fails++;
    end_sim();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    ext_edge_rising = 1'b1;
    port_a_pin_change_mask = 8'h00;
    port_b_pin_change_mask = 8'h00;
    op = 3'h0;
    arg = 8'h00;
    rd_seen = 1'b0;
    v = 8'($urandom(32'hffff));
    for (int r = 0; r < 2; r++)
    begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(INTERRUPT_CONTROL_OFS3, 8'h00);
      rd(PERIPHERAL_IRQ_ENABLE_ONE_OFS, 8'h00);
      rd(9'h1ff, 8'h00);
      wr(INTERRUPT_CONTROL_OFS0, 8'hf8);
      wr(PERIPHERAL_IRQ_ENABLE_ONE_OFS, 8'hff);
      @(posedge clk_sys);
      if (r == 0)
        rst_n <= 1'b0;
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom()) & 8'hf8;
      wr({i[1:0], 7'h0b}, v);
      for (int j = 0; j < 4; j++)
        rd({j[1:0], 7'h0b}, v);
    end
    wr(PERIPHERAL_IRQ_ENABLE_ONE_OFS, 8'hff);
    rd(PERIPHERAL_IRQ_ENABLE_ONE_OFS, 8'h7f);
    for (int k = 0; k < 3; k++)
    begin
      wr(INTERRUPT_CONTROL_OFS1, 8'h00);
      src(3'(k + 1), 8'h00);
      repeat (6) @(posedge clk_sys);
      rd(INTERRUPT_CONTROL_OFS2, 8'h04 >> k);
      irq_is(1'b0);
      wr(INTERRUPT_CONTROL_OFS3, 8'h80 | (8'h24 >> k));
      irq_is(1'b1);
      wr(INTERRUPT_CONTROL_OFS0, 8'h80 | (8'h04 >> k));
      irq_is(1'b0);
      rd(INTERRUPT_CONTROL_OFS0, 8'h80 | (8'h04 >> k));
    end
    // The external pin is high here; a falling edge must now raise the flag.
    ext_edge_rising <= 1'b0;
    wr(INTERRUPT_CONTROL_OFS0, 8'h00);
    src(3'h2, 8'h00);
    repeat (6) @(posedge clk_sys);
    rd(INTERRUPT_CONTROL_OFS0, 8'h02);
    wr(INTERRUPT_CONTROL_OFS0, 8'h00);
    src(3'h4, 8'h01);
    repeat (6) @(posedge clk_sys);
    rd(INTERRUPT_CONTROL_OFS0, 8'h00);
    port_b_pin_change_mask <= 8'h08;
    src(3'h5, 8'h08);
    repeat (6) @(posedge clk_sys);
    rd(INTERRUPT_CONTROL_OFS0, 8'h01);
    wr(INTERRUPT_CONTROL_OFS0, 8'h00);
    for (int k = 0; k < 7; k++)
    begin
      v = 8'h01 << k;
      src(3'h6, v | (8'($urandom()) & ~v));
      wr(PERIPHERAL_IRQ_ENABLE_ONE_OFS, v);
      wr(INTERRUPT_CONTROL_OFS1, 8'h80);
      irq_is(1'b0);
      wr(INTERRUPT_CONTROL_OFS1, 8'hc0);
      irq_is(1'b1);
      src(3'h6, ~v);
      irq_is(1'b0);
    end
    wr(INTERRUPT_CONTROL_OFS1, 8'ha0);
    src(3'h1, 8'h00);
    irq_is(1'b1);
    wr(INTERRUPT_CONTROL_OFS1, 8'h88);
    src(3'h3, 8'h00);
    irq_is(1'b1);
    wr(INTERRUPT_CONTROL_OFS1, 8'h00);
    wr(EVENT_STATUS_OFS, 8'h0f);
    wr(EVENT_MASK_OFS, 8'h01);
    src(3'h1, 8'h00);
    repeat (3) @(posedge clk_sys);
    check("irq_event", {7'h00, irq_event}, 8'h01);
    wr(EVENT_STATUS_OFS, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("irq_event", {7'h00, irq_event}, 8'h00);
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule : testbench
